/* rtl/iepr_arbiter.sv */
// Two-level fixed-order arbiter over the enabled request vector
`timescale 1ns/1ns
module iepr_arbiter (
	input wire logic [14:0] cand_hi,
	input wire logic [14:0] cand_lo,
	output logic valid,
	output logic high,
	output logic [3:0] id
);

	// Lowest index wins, so external interrupt 0 is first
	function automatic logic [3:0] first_set(input logic [14:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = iepr_pkg::NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	always_comb begin
		valid = (|cand_hi) | (|cand_lo);
		high = |cand_hi;
		if (|cand_hi) begin
			id = first_set(cand_hi);
		end else begin
			id = first_set(cand_lo);
		end
	end

endmodule // iepr_arbiter

/* rtl/iepr_pkg.sv */
// Constants shared by the interrupt enable and priority register block
package iepr_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_ENABLE_MAIN = 8'hA8;
	localparam logic [7:0] IDX_PRIORITY_MAIN = 8'hB8;
	localparam logic [7:0] IDX_ENABLE_EXT = 8'hE6;
	localparam logic [7:0] IDX_PRIORITY_EXT = 8'hF6;
	localparam int IDX_LSB = 2;

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_ENABLE_MAIN = 8'h00;
	localparam logic [7:0] RST_PRIORITY_MAIN = 8'h80;
	localparam logic [7:0] RST_ENABLE_EXT = 8'h00;
	localparam logic [7:0] RST_PRIORITY_EXT = 8'h00;
	localparam int GLOBAL_BIT = 7;
	localparam int PRIO_TOP_BIT = 7;
	localparam logic PRIO_TOP_READ = 1'b1;

	// ----------------------------------------
	// Sources, in fixed arbitration order
	// ----------------------------------------
	localparam int NSRC = 15;
	localparam int SRC_W = 4;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_SPI = 4'h6;
	localparam logic [3:0] SRC_TIMER3 = 4'hE;

	// ----------------------------------------
	// Bus encodings and timing
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam real CLK_PERIOD_NS = 8.0;
	localparam int DETECT_TIME_CYCLES = 1;
	localparam int DETECT_CYCLES = DETECT_TIME_CYCLES;

endpackage

/* rtl/iepr_regs.sv */
// Interrupt enable and priority registers with request arbitration
//
// Summary of operation
// - Global enable cleared blocks every source regardless of source enables.
// - With global enable set, each source follows its own enable bit.
// - Main enable bit 6 gates the SPI request.
// - Main enable bit 5 gates timer 2, raised by low or high overflow.
// - Main enable bit 4 gates the UART request.
// - Main enable bit 3 gates the timer 1 overflow request.
// - Main enable bit 2 gates external interrupt 1.
// - Main enable bit 1 gates the timer 0 overflow request.
// - Main enable bit 0 gates external interrupt 0.
// - Main priority bit 7 always reads 1; writes to it are ignored.
// - Main priority bits 6..4 set SPI, timer 2, UART level.
// - Main priority bits 3..0 set timer 1, ext 1, timer 0, ext 0.
// - Extended enable bit 7 gates timer 3, low or high overflow.
// - Extended enable bits 6, 5 gate comparator 1 and 0 edge flags.
// - Extended enable bit 4 gates the counter array requests.
// - Extended enable bits 3, 2 gate conversion done and window compare.
// - Extended enable bits 1, 0 gate USB and SMBus requests.
// - Extended priority bits 7..0 set levels of the extended sources.
// - High requests preempt low routines; high routines are never preempted.
// - Higher level wins; equal levels use fixed order, external 0 first.
// - Requests are sampled and decoded every cycle: one cycle detection.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module iepr_regs (
	input wire logic mclk,
	input wire logic arst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pending flags from peripherals
	input wire logic ext_irq0_pin,
	input wire logic timer0_overflow_flag,
	input wire logic ext_irq1_pin,
	input wire logic timer1_overflow_flag,
	input wire logic uart_pending,
	input wire logic timer2_low_overflow_flag,
	input wire logic timer2_high_overflow_flag,
	input wire logic spi_pending,
	input wire logic smbus_pending,
	input wire logic usb_pending,
	input wire logic window_compare_flag,
	input wire logic conversion_done_flag,
	input wire logic counter_array_pending,
	input wire logic cmp0_rising_flag,
	input wire logic cmp0_falling_flag,
	input wire logic cmp1_rising_flag,
	input wire logic cmp1_falling_flag,
	input wire logic timer3_low_overflow_flag,
	input wire logic timer3_high_overflow_flag,
	// Core sequencer side
	input wire logic isr_enter,
	input wire logic isr_return,
	output logic irq_req,
	output logic irq_high,
	output logic [3:0] irq_id
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] enable_main;
		logic [6:0] priority_main;
		logic [7:0] enable_ext;
		logic [7:0] priority_ext;
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_idx;
		logic [31:0] rdata;
		logic readyout;
		logic resp;
		logic req;
		logic high;
		logic [3:0] id;
	} iepr_state_s;

	iepr_state_s st;
	iepr_state_s next_st;

	logic [14:0] pending;
	logic [14:0] en_vec;
	logic [14:0] prio_vec;
	logic [14:0] enabled;
	logic [14:0] cand_hi;
	logic [14:0] cand_lo;
	logic glob;
	logic block_lo;
	logic block_hi;
	logic arb_valid;
	logic arb_high;
	logic [3:0] arb_id;
	logic addr_ok;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Only word-aligned accesses in the low kilobyte can hit a register
	function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
		return (a[31:10] == 22'h0) && (a[1:0] == 2'h0)
			&& (a[9:iepr_pkg::IDX_LSB] == idx);
	endfunction

	function automatic logic [7:0] read_val(input iepr_state_s s, input logic [31:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (hit(a, iepr_pkg::IDX_ENABLE_MAIN)) begin
			r = s.enable_main;
		end
		if (hit(a, iepr_pkg::IDX_PRIORITY_MAIN)) begin
			r = {iepr_pkg::PRIO_TOP_READ, s.priority_main};
		end
		if (hit(a, iepr_pkg::IDX_ENABLE_EXT)) begin
			r = s.enable_ext;
		end
		if (hit(a, iepr_pkg::IDX_PRIORITY_EXT)) begin
			r = s.priority_ext;
		end
		return r;
	endfunction

	assign addr_ok = hsel && hready && (htrans == iepr_pkg::HTRANS_NONSEQ || htrans == 2'h3);

	// ----------------------------------------
	// Source requests
	// ----------------------------------------
	// Vector order is the fixed arbitration order; enable and priority
	// bits line up with it as {extended, main[6:0]}.
	assign pending = {
		timer3_low_overflow_flag | timer3_high_overflow_flag,
		cmp1_rising_flag | cmp1_falling_flag,
		cmp0_rising_flag | cmp0_falling_flag,
		counter_array_pending,
		conversion_done_flag,
		window_compare_flag,
		usb_pending,
		smbus_pending,
		spi_pending,
		timer2_low_overflow_flag | timer2_high_overflow_flag,
		uart_pending,
		timer1_overflow_flag,
		ext_irq1_pin,
		timer0_overflow_flag,
		ext_irq0_pin
	};

	assign glob = st.enable_main[iepr_pkg::GLOBAL_BIT];
	assign en_vec = {st.enable_ext, st.enable_main[6:0]};
	assign prio_vec = {st.priority_ext, st.priority_main};

	// Flags are only looked at, so a masked source stays pending
	assign enabled = pending & en_vec & {15{glob}};

	assign cand_hi = block_hi ? 15'h0000 : (enabled & prio_vec);
	assign cand_lo = block_lo ? 15'h0000 : (enabled & ~prio_vec);

	iepr_arbiter u_arb (
		.cand_hi(cand_hi),
		.cand_lo(cand_lo),
		.valid(arb_valid),
		.high(arb_high),
		.id(arb_id)
	);

	iepr_service_track u_track (
		.mclk(mclk),
		.arst_n(arst_n),
		.isr_enter(isr_enter),
		.isr_enter_high(st.high),
		.isr_return(isr_return),
		.block_lo(block_lo),
		.block_hi(block_hi)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.readyout = 1'b1;
		next_st.resp = 1'b0;
		// Data phase write lands first so a read right behind sees it
		if (st.dp_valid && st.dp_write) begin
			case (st.dp_idx)
				iepr_pkg::IDX_ENABLE_MAIN: begin
					next_st.enable_main = hwdata[7:0];
				end
				iepr_pkg::IDX_PRIORITY_MAIN: begin
					next_st.priority_main = hwdata[6:0];
				end
				iepr_pkg::IDX_ENABLE_EXT: begin
					next_st.enable_ext = hwdata[7:0];
				end
				iepr_pkg::IDX_PRIORITY_EXT: begin
					next_st.priority_ext = hwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		if (hready) begin
			next_st.dp_valid = addr_ok;
			next_st.dp_write = hwrite;
			next_st.dp_idx = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0
				? haddr[9:2] : 8'h00;
			if (addr_ok && !hwrite) begin
				next_st.rdata = {24'h0, read_val(next_st, haddr)};
			end
		end
		// Detection is a single registered stage
		next_st.req = arb_valid;
		next_st.high = arb_high;
		next_st.id = arb_id;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{
				enable_main: iepr_pkg::RST_ENABLE_MAIN,
				priority_main: iepr_pkg::RST_PRIORITY_MAIN[6:0],
				enable_ext: iepr_pkg::RST_ENABLE_EXT,
				priority_ext: iepr_pkg::RST_PRIORITY_EXT,
				readyout: 1'b1,
				default: '0
			};
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.rdata;
	assign hreadyout = st.readyout;
	assign hresp = st.resp;
	assign irq_req = st.req;
	assign irq_high = st.high;
	assign irq_id = st.id;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	logic [14:0] below_mask;
	logic [14:0] sel_vec;
	assign below_mask = 15'((16'h1 << arb_id) - 16'h1);
	assign sel_vec = arb_high ? cand_hi : cand_lo;

	sequence s_rd_prio;
		addr_ok && !hwrite && hit(haddr, iepr_pkg::IDX_PRIORITY_MAIN);
	endsequence

	sequence s_wr_enable;
		addr_ok && hwrite && hit(haddr, iepr_pkg::IDX_ENABLE_MAIN) ##1 hready;
	endsequence

	sequence s_detect_out;
		irq_req && irq_id == $past(arb_id) && irq_high == $past(arb_high);
	endsequence

	sequence s_wr_prio;
		addr_ok && hwrite && hit(haddr, iepr_pkg::IDX_PRIORITY_MAIN) ##1 hready;
	endsequence

	sequence s_wr_ext_enable;
		addr_ok && hwrite && hit(haddr, iepr_pkg::IDX_ENABLE_EXT) ##1 hready;
	endsequence

	sequence s_wr_ext_prio;
		addr_ok && hwrite && hit(haddr, iepr_pkg::IDX_PRIORITY_EXT) ##1 hready;
	endsequence

	a_global_off_quiet: assert property (!glob |=> !irq_req)
		else $error("request raised with global enable clear");
	a_grant_enabled: assert property (arb_valid |-> glob && en_vec[arb_id]
		&& pending[arb_id])
		else $error("granted source is not pending and enabled");
	a_spi_masked: assert property (!st.enable_main[6] |=>
		!(irq_req && irq_id == iepr_pkg::SRC_SPI))
		else $error("masked spi source requested");
	a_prio_top_one: assert property (s_rd_prio |=> hrdata[iepr_pkg::PRIO_TOP_BIT])
		else $error("priority top bit did not read one");
	a_high_beats_low: assert property (|cand_hi |-> arb_valid && arb_high
		&& prio_vec[arb_id])
		else $error("high level request lost to low");
	a_fixed_order: assert property (arb_valid |-> sel_vec[arb_id]
		&& (sel_vec & below_mask) == 15'h0000)
		else $error("equal level order violated");
	a_high_no_preempt: assert property (block_hi |-> !arb_valid ##1 !irq_req)
		else $error("high routine preempted");
	a_low_preempted: assert property (block_lo && !block_hi && |(enabled & prio_vec)
		|=> irq_req && irq_high)
		else $error("low routine not preempted by high request");
	a_one_cycle_detect: assert property (arb_valid |=> s_detect_out)
		else $error("request not forwarded after one cycle");
	a_enable_write: assert property (s_wr_enable |=> st.enable_main == $past(hwdata[7:0]))
		else $error("enable write not stored");
	// External 0 only wins when no higher level competes with it
	a_pending_gates: assert property (glob && en_vec[iepr_pkg::SRC_EXT0] && ext_irq0_pin
		&& (prio_vec[iepr_pkg::SRC_EXT0] ? !block_hi : (!block_lo && cand_hi == 15'h0000))
		|=> irq_req && irq_id == iepr_pkg::SRC_EXT0)
		else $error("enabled external 0 request not forwarded");

	// ----------------------------------------
	// Storage and per-source gating checks
	// ----------------------------------------
	a_prio_write: assert property (s_wr_prio |=> st.priority_main == $past(hwdata[6:0]))
		else $error("priority write not stored");
	a_ext_enable_write: assert property (s_wr_ext_enable
		|=> st.enable_ext == $past(hwdata[7:0]))
		else $error("extended enable write not stored");
	a_ext_prio_write: assert property (s_wr_ext_prio
		|=> st.priority_ext == $past(hwdata[7:0]))
		else $error("extended priority write not stored");
	a_timer2_either: assert property (glob && st.enable_main[5]
		&& timer2_high_overflow_flag |-> enabled[5])
		else $error("timer 2 high overflow not requested");
	a_uart_masked: assert property (!st.enable_main[4] |-> !enabled[4])
		else $error("masked uart source enabled");
	a_timer1_masked: assert property (!st.enable_main[3] |-> !enabled[3])
		else $error("masked timer 1 source enabled");
	a_ext1_masked: assert property (!st.enable_main[2] |-> !enabled[2])
		else $error("masked external 1 source enabled");
	a_timer0_masked: assert property (!st.enable_main[1] |-> !enabled[1])
		else $error("masked timer 0 source enabled");
	a_ext0_masked: assert property (!st.enable_main[0] |-> !enabled[0])
		else $error("masked external 0 source enabled");
	a_timer3_either: assert property (glob && st.enable_ext[7]
		&& timer3_low_overflow_flag |-> enabled[14])
		else $error("timer 3 low overflow not requested");
	a_cmp_either: assert property (glob && st.enable_ext[6] && cmp1_falling_flag
		&& st.enable_ext[5] && cmp0_rising_flag |-> enabled[13] && enabled[12])
		else $error("comparator edge flag not requested");
	a_counter_masked: assert property (!st.enable_ext[4] |-> !enabled[11])
		else $error("masked counter array source enabled");
	a_adc_masked: assert property (enabled[10:9] == (enabled[10:9] & st.enable_ext[3:2]))
		else $error("masked converter source enabled");
	a_usb_smbus_masked: assert property (enabled[8:7] == (enabled[8:7] & st.enable_ext[1:0]))
		else $error("masked usb or smbus source enabled");

endmodule // iepr_regs

/* rtl/iepr_service_track.sv */
// Tracks which priority levels have a service routine in progress
`timescale 1ns/1ns
module iepr_service_track (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic isr_enter,
	input wire logic isr_enter_high,
	input wire logic isr_return,
	output logic block_lo,
	output logic block_hi
);

	typedef struct packed {
		logic act_hi;
		logic act_lo;
	} iepr_track_s;

	iepr_track_s st;
	iepr_track_s next_st;

	always_comb begin
		next_st = st;
		// Return closes the innermost level, which is high if active
		if (isr_return) begin
			if (st.act_hi) begin
				next_st.act_hi = 1'b0;
			end else begin
				next_st.act_lo = 1'b0;
			end
		end
		if (isr_enter) begin
			if (isr_enter_high) begin
				next_st.act_hi = 1'b1;
			end else begin
				next_st.act_lo = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign block_lo = st.act_lo | st.act_hi;
	assign block_hi = st.act_hi;

endmodule // iepr_service_track

/* verif/iepr_core_model.sv */
// Stand-in for the core sequencer: vectors and returns on command
`timescale 1ns/1ns
module iepr_core_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic irq_req,
	input wire logic take,
	input wire logic give_back,
	output logic isr_enter,
	output logic isr_return
);
	// Vectors only while a request is shown, as a real core would
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			isr_enter <= 1'b0;
			isr_return <= 1'b0;
		end else begin
			isr_enter <= take & irq_req;
			isr_return <= give_back;
		end
	end
endmodule // iepr_core_model

/* verif/interrupt_enable_priority_regs_bench.sv */
// Self-checking bench for the interrupt enable and priority registers
`timescale 1ns/1ns
module interrupt_enable_priority_regs_bench;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq_req, irq_high, isr_enter, isr_return;
	logic [3:0] irq_id;
	logic [18:0] fl = 19'h0;
	logic take = 1'b0;
	logic give_back = 1'b0;
	// Shadows: {extended, main}; service levels as the bench expects them
	logic [15:0] en = 16'h0;
	logic [15:0] pr = 16'h0080;
	logic svc_hi = 1'b0;
	logic svc_lo = 1'b0;
	logic [7:0] rd;
	logic [7:0] idx_t [4] = '{iepr_pkg::IDX_ENABLE_MAIN, iepr_pkg::IDX_PRIORITY_MAIN,
		iepr_pkg::IDX_ENABLE_EXT, iepr_pkg::IDX_PRIORITY_EXT};
	logic [7:0] rst_t [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
	int failures = 0;
	int n_checks = 0;

	always #4 mclk = ~mclk;

	iepr_regs uut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_irq0_pin(fl[0]),
		.timer0_overflow_flag(fl[1]), .ext_irq1_pin(fl[2]), .timer1_overflow_flag(fl[3]),
		.uart_pending(fl[4]), .timer2_low_overflow_flag(fl[5]),
		.timer2_high_overflow_flag(fl[6]), .spi_pending(fl[7]), .smbus_pending(fl[8]),
		.usb_pending(fl[9]), .window_compare_flag(fl[10]), .conversion_done_flag(fl[11]),
		.counter_array_pending(fl[12]), .cmp0_rising_flag(fl[13]), .cmp0_falling_flag(fl[14]),
		.cmp1_rising_flag(fl[15]), .cmp1_falling_flag(fl[16]),
		.timer3_low_overflow_flag(fl[17]), .timer3_high_overflow_flag(fl[18]),
		.isr_enter(isr_enter), .isr_return(isr_return), .irq_req(irq_req),
		.irq_high(irq_high), .irq_id(irq_id));

	iepr_core_model core (.mclk(mclk), .arst_n(arst_n), .irq_req(irq_req), .take(take),
		.give_back(give_back), .isr_enter(isr_enter), .isr_return(isr_return));

	// ----------------------------------------
	// Expectations and comparisons
	// ----------------------------------------
	// Packed as {2'b0, req, high, id}; lowest source number wins a level
	function automatic logic [7:0] expect_irq();
		logic [14:0] p, act, hi, lo;
		p = {fl[17] | fl[18], fl[15] | fl[16], fl[13] | fl[14], fl[12:7], fl[5] | fl[6], fl[4:0]};
		act = p & {en[15:8], en[6:0]} & {15{en[7]}};
		hi = svc_hi ? 15'h0 : act & {pr[15:8], pr[6:0]};
		lo = (svc_hi | svc_lo) ? 15'h0 : act & ~{pr[15:8], pr[6:0]};
		expect_irq = 8'h00;
		for (int i = 14; i >= 0; i--) if (lo[i]) expect_irq = {4'h2, i[3:0]};
		for (int i = 14; i >= 0; i--) if (hi[i]) expect_irq = {4'h3, i[3:0]};
	endfunction

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Level and source number mean nothing while no request is shown
	task automatic chk_irq();
		repeat (2) @(posedge mclk);
		#1;
		chk8({2'h0, irq_req, irq_req ? {irq_high, irq_id} : 5'h0}, expect_irq());
		@(posedge mclk);
	endtask

	// ----------------------------------------
	// Bus and sequencer drivers
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= iepr_pkg::HTRANS_NONSEQ;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata[7:0];
	endtask

	task automatic set_regs(input logic [15:0] e, input logic [15:0] p);
		// Table order is main enable, main priority, extended enable, extended priority
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, idx_t[i], i[0] ? p[(i / 2) * 8 +: 8] : e[(i / 2) * 8 +: 8]);
		end
		en = e;
		pr = p | 16'h0080;
	endtask

	// Return is applied before entry, matching the sequencer's order
	task automatic svc(input logic e, input logic r);
		logic [7:0] x;
		x = expect_irq();
		take <= e;
		give_back <= r;
		@(posedge mclk);
		take <= 1'b0;
		give_back <= 1'b0;
		@(posedge mclk);
		if (r) begin
			if (svc_hi) svc_hi = 1'b0;
			else svc_lo = 1'b0;
		end
		if (e && x[5]) begin
			if (x[4]) svc_hi = 1'b1;
			else svc_lo = 1'b1;
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int s;
		logic [15:0] own;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, idx_t[i], 8'h00);
			chk8(rd, rst_t[i]);
		end
		chk_irq();
		$display("Test reset values done");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, idx_t[i], 8'hFF);
			xfer(1'b0, idx_t[i], 8'h00);
			chk8(rd, 8'hFF);
			xfer(1'b1, idx_t[i], 8'h00);
			xfer(1'b0, idx_t[i], 8'h00);
			chk8(rd, rst_t[i]);
		end
		xfer(1'b1, 8'h40, 8'h5A);
		xfer(1'b0, 8'h40, 8'h00);
		chk8(rd, 8'h00);
		chk8({7'h00, hresp}, 8'h00);
		$display("Test register access done");
		for (int f = 0; f < 19; f++) begin
			s = f < 5 ? f : f < 7 ? 5 : f < 13 ? f - 1 : f < 15 ? 12 : f < 17 ? 13 : 14;
			own = 16'h1 << (s < 7 ? s : s + 1);
			fl <= 19'h1 << f;
			set_regs(16'hFF7F, 16'h0000);
			chk_irq();
			set_regs(~own, 16'h0000);
			chk_irq();
			set_regs(own | 16'h0080, f[0] ? own : 16'h0000);
			chk_irq();
		end
		$display("Test source gating done");
		fl <= 19'h7FFFF;
		set_regs(16'hFFFF, 16'h0000);
		chk_irq();
		set_regs(16'hFFFF, 16'h8000);
		chk_irq();
		set_regs(16'hFFFF, 16'hFFFF);
		chk_irq();
		$display("Test arbitration done");
		fl <= 19'h00001;
		set_regs(16'hFFFF, 16'h0008);
		chk_irq();
		svc(1'b1, 1'b0);
		chk_irq();
		fl <= 19'h00009;
		chk_irq();
		svc(1'b1, 1'b0);
		chk_irq();
		svc(1'b0, 1'b1);
		chk_irq();
		fl <= 19'h00001;
		chk_irq();
		svc(1'b0, 1'b1);
		chk_irq();
		$display("Test preemption done");
		summarize();
	end

	// Whole run needs about 750 cycles; this bound is far beyond it
	initial begin
		#100000;
		failures++;
		summarize();
	end
endmodule // interrupt_enable_priority_regs_bench
